// ---- hdl/mie_pkg.sv ----
// Package of offsets, field positions, reset values and codes for the execute unit.
package mie_pkg;

  // ----------------------------------------------------------------
  // Register byte addresses
  // ----------------------------------------------------------------
  localparam logic [11:0] OFS_INSTR  = 12'h000;
  localparam logic [11:0] OFS_WREG   = 12'h004;
  localparam logic [11:0] OFS_PC     = 12'h008;
  localparam logic [11:0] OFS_FLAGS  = 12'h00C;
  localparam logic [11:0] OFS_CTRL   = 12'h010;
  localparam logic [11:0] OFS_STACK  = 12'h014;
  localparam logic [11:0] OFS_SP     = 12'h018;
  localparam logic [11:0] OFS_IRQCTL = 12'h01C;
  localparam logic [11:0] OFS_MEM    = 12'h100;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int INSTR_OP_LSB  = 0;
  localparam int INSTR_IMM_LSB = 8;
  localparam int INSTR_OPD_LSB = 16;
  localparam int FLG_ZERO      = 0;
  localparam int FLG_CARRY     = 1;
  localparam int FLG_SLEEP     = 2;
  localparam int FLG_WDOG      = 3;
  localparam int FLG_BUSY      = 8;
  localparam int FLG_HALTED    = 9;
  localparam int IRQ_GIE       = 0;
  localparam int CTRL_WAKE     = 0;

  // ----------------------------------------------------------------
  // Reset values and timing
  // ----------------------------------------------------------------
  localparam logic [7:0] RST_BYTE    = 8'h00;
  localparam logic [7:0] ONE_BYTE    = 8'h01;
  localparam int         RET_CYCLES  = 2;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [4:0] {
    OP_INC, OP_INCA, OP_JMP, OP_MOVAM, OP_MOVAX, OP_MOVMA, OP_NOP, OP_ORAM,
    OP_ORAX, OP_ORMM, OP_RET, OP_RETAX, OP_RETI, OP_RL, OP_RLA, OP_RLC,
    OP_RLCA, OP_RR, OP_RRA, OP_RRC, OP_RRCA, OP_HALT
  } mie_op_t;

  typedef enum logic [1:0] {ST_IDLE, ST_EXEC, ST_RET2} mie_fsm_t;

endpackage

// ---- hdl/mie_exec.sv ----
// Execute unit for increment, jump, move, no-op, OR, returns, halt and rotates.
//
// The address map and the APB slave port were chosen for this implementation.
`timescale 1ns/100ps
module mie_exec
  import mie_pkg::*;
#(
  parameter int PC_W      = 12,
  parameter int DM_DEPTH  = 32,
  parameter int STK_DEPTH = 8
) (
  input  wire logic        mclk,
  input  wire logic        sys_rst,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  output logic             core_clk_stop,
  output logic             global_irq_enable
);

  localparam int AW = $clog2(DM_DEPTH);
  localparam int SW = $clog2(STK_DEPTH);
  localparam logic [11:0] MEM_END = 12'(OFS_MEM + 12'(4 * DM_DEPTH));

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    mie_fsm_t                       fsm;
    logic                           pready;
    logic                           pslverr;
    logic [31:0]                    prdata;
    logic [7:0]                     wreg;
    logic [PC_W-1:0]                pc;
    logic                           zf;
    logic                           cf;
    logic                           gie;
    logic                           sleepf;
    logic                           wdf;
    logic                           halted;
    mie_op_t                        op;
    logic [7:0]                     imm;
    logic [PC_W-1:0]                opnd;
    logic [DM_DEPTH-1:0][7:0]       mem;
    logic [STK_DEPTH-1:0][PC_W-1:0] stk;
    logic [SW-1:0]                  sp;
  } mie_state_t;

  mie_state_t      st;
  mie_state_t      next_st;
  logic [AW-1:0]   idx;
  logic [7:0]      mop;
  logic [8:0]      rot;
  logic            left;
  logic            thru;
  logic            xfer;
  logic            hit;
  logic [31:0]     rd_val;
  logic [SW-1:0]   sp_top;
  logic [AW-1:0]   bus_idx;

  // Rotates a byte one place; the leaving bit sits on top of the result.
  function automatic logic [8:0] rot9(input logic [7:0] v, input logic lft, input logic fill);
    rot9 = lft ? {v[7], v[6:0], fill} : {v[0], fill, v[7:1]};
  endfunction

  // Tells whether a byte result is zero.
  function automatic logic is_zero(input logic [7:0] v);
    is_zero = (v == RST_BYTE);
  endfunction

  // ----------------------------------------------------------------
  // Operand fetch and decode
  // ----------------------------------------------------------------
  // The operand byte follows from the latched operand; rotate direction and carry use follow from the latched opcode.
  assign idx     = st.opnd[AW-1:0];
  assign mop     = st.mem[idx];
  assign left    = st.op inside {OP_RL, OP_RLA, OP_RLC, OP_RLCA};
  assign thru    = st.op inside {OP_RLC, OP_RLCA, OP_RRC, OP_RRCA};
  assign rot     = rot9(mop, left, thru ? st.cf : (left ? mop[7] : mop[0]));
  assign sp_top  = SW'(st.sp - 1'b1);
  assign xfer    = psel && penable;
  assign bus_idx = AW'(paddr[11:2] - OFS_MEM[11:2]);

  // Read data and address decode; a busy unit refuses a new instruction.
  always_comb begin
    rd_val = 32'h0000_0000;
    hit    = 1'b1;
    if (paddr >= OFS_MEM && paddr < MEM_END && paddr[1:0] == 2'h0) begin
      rd_val = {24'h00_0000, st.mem[bus_idx]};
    end else begin
      unique case (paddr)
        OFS_INSTR:  hit = pwrite && st.fsm == ST_IDLE && !st.halted;
        OFS_WREG:   rd_val = {24'h00_0000, st.wreg};
        OFS_PC:     rd_val = 32'(st.pc);
        OFS_FLAGS:  rd_val = 32'({st.halted, st.fsm != ST_IDLE, 4'h0, st.wdf, st.sleepf, st.cf, st.zf});
        OFS_CTRL:   rd_val = 32'h0000_0000;
        OFS_STACK:  rd_val = 32'(st.stk[sp_top]);
        OFS_SP:     rd_val = 32'(st.sp);
        OFS_IRQCTL: rd_val = 32'(st.gie);
        default:    hit = 1'b0;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    next_st = st;
    // Instruction execution; every form not changing flow advances the counter.
    unique case (st.fsm)
      ST_IDLE: next_st.fsm = ST_IDLE;
      ST_EXEC: begin
        next_st.fsm = ST_IDLE;
        next_st.pc  = PC_W'(st.pc + 1'b1);
        case (st.op)
          OP_INC: begin
            next_st.mem[idx] = 8'(mop + ONE_BYTE);
            next_st.zf       = is_zero(8'(mop + ONE_BYTE));
          end
          OP_INCA: begin
            next_st.wreg = 8'(mop + ONE_BYTE);
            next_st.zf   = is_zero(8'(mop + ONE_BYTE));
          end
          OP_JMP:   next_st.pc = st.opnd;
          OP_MOVAM: next_st.wreg = mop;
          OP_MOVAX: next_st.wreg = st.imm;
          OP_MOVMA: next_st.mem[idx] = st.wreg;
          OP_NOP:   next_st.pc = PC_W'(st.pc + 1'b1);
          OP_ORAM: begin
            next_st.wreg = st.wreg | mop;
            next_st.zf   = is_zero(st.wreg | mop);
          end
          OP_ORAX: begin
            next_st.wreg = st.wreg | st.imm;
            next_st.zf   = is_zero(st.wreg | st.imm);
          end
          OP_ORMM: begin
            next_st.mem[idx] = st.wreg | mop;
            next_st.zf       = is_zero(st.wreg | mop);
          end
          OP_RET, OP_RETAX, OP_RETI: begin
            next_st.pc  = st.stk[sp_top];
            next_st.sp  = sp_top;
            next_st.fsm = ST_RET2;
            if (st.op == OP_RETAX) begin
              next_st.wreg = st.imm;
            end
            if (st.op == OP_RETI) begin
              next_st.gie = 1'b1;
            end
          end
          OP_RL, OP_RR, OP_RLC, OP_RRC: begin
            next_st.mem[idx] = rot[7:0];
            if (thru) begin
              next_st.cf = rot[8];
            end
          end
          OP_RLA, OP_RRA, OP_RLCA, OP_RRCA: begin
            next_st.wreg = rot[7:0];
            if (thru) begin
              next_st.cf = rot[8];
            end
          end
          OP_HALT: begin
            next_st.halted = 1'b1;
            next_st.sleepf = 1'b1;
            next_st.wdf    = 1'b0;
          end
          default: next_st.pc = PC_W'(st.pc + 1'b1);
        endcase
      end
      ST_RET2: next_st.fsm = ST_IDLE;
    endcase
    // Bus slave: one wait state, then the write lands on the edge that sees pready.
    if (xfer && !st.pready) begin
      next_st.pready  = 1'b1;
      next_st.pslverr = !hit;
      next_st.prdata  = hit ? rd_val : 32'h0000_0000;
    end else if (st.pready) begin
      next_st.pready  = 1'b0;
      next_st.pslverr = 1'b0;
      if (xfer && pwrite && !st.pslverr) begin
        if (paddr >= OFS_MEM) begin
          next_st.mem[bus_idx] = pwdata[7:0];
        end else begin
          unique case (paddr)
            OFS_INSTR: begin
              next_st.op   = mie_op_t'(pwdata[INSTR_OP_LSB +: 5]);
              next_st.imm  = pwdata[INSTR_IMM_LSB +: 8];
              next_st.opnd = pwdata[INSTR_OPD_LSB +: PC_W];
              next_st.fsm  = ST_EXEC;
            end
            OFS_WREG:   next_st.wreg = pwdata[7:0];
            OFS_PC:     next_st.pc = pwdata[PC_W-1:0];
            OFS_FLAGS: begin
              next_st.zf     = pwdata[FLG_ZERO];
              next_st.cf     = pwdata[FLG_CARRY];
              next_st.sleepf = pwdata[FLG_SLEEP];
              next_st.wdf    = pwdata[FLG_WDOG];
            end
            OFS_CTRL: begin
              if (pwdata[CTRL_WAKE]) begin
                next_st.halted = 1'b0;
              end
            end
            OFS_STACK: begin
              next_st.stk[st.sp] = pwdata[PC_W-1:0];
              next_st.sp         = SW'(st.sp + 1'b1);
            end
            OFS_IRQCTL: next_st.gie = pwdata[IRQ_GIE];
            default:    next_st.sp = st.sp;
          endcase
        end
      end
    end
  end

  // Registers the whole state; memory and stack clear on reset.
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  // Outputs come straight from state flip-flops.
  assign prdata            = st.prdata;
  assign pready            = st.pready;
  assign pslverr           = st.pslverr;
  assign core_clk_stop     = st.halted;
  assign global_irq_enable = st.gie;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);

  sequence s_exec(mie_op_t o);
    st.fsm == ST_EXEC && st.op == o;
  endsequence

  sequence s_ret_tail;
    st.fsm == ST_RET2 ##1 st.fsm == ST_IDLE;
  endsequence

  a_inc_store: assert property (s_exec(OP_INC) |=> st.mem[$past(idx)] == 8'($past(mop) + ONE_BYTE)
    && st.zf == (st.mem[$past(idx)] == RST_BYTE) && st.cf == $past(st.cf))
    else $error("INC result or flags wrong");
  a_inca_reg: assert property (s_exec(OP_INCA) |=> st.wreg == 8'($past(mop) + ONE_BYTE)
    && st.mem == $past(st.mem) && st.zf == (st.wreg == RST_BYTE))
    else $error("INCA result or zero flag wrong");
  a_jmp_target: assert property (s_exec(OP_JMP) |=> st.pc == $past(st.opnd) && st.zf == $past(st.zf))
    else $error("JMP target wrong");
  a_mov_to_reg: assert property (s_exec(OP_MOVAM) |=> st.wreg == $past(mop) && st.zf == $past(st.zf))
    else $error("memory move to working register wrong");
  a_mov_imm: assert property (s_exec(OP_MOVAX) |=> st.wreg == $past(st.imm))
    else $error("immediate move wrong");
  a_mov_to_mem: assert property (s_exec(OP_MOVMA) |=> st.mem[$past(idx)] == $past(st.wreg))
    else $error("working register move to memory wrong");
  a_nop_step: assert property (s_exec(OP_NOP) |=> st.pc == PC_W'($past(st.pc) + 1'b1)
    && st.wreg == $past(st.wreg) && st.mem == $past(st.mem))
    else $error("NOP changed state");
  a_or_imm: assert property (s_exec(OP_ORAX) |=> st.wreg == ($past(st.wreg) | $past(st.imm))
    && st.zf == (st.wreg == RST_BYTE))
    else $error("OR immediate wrong");
  a_ret_two: assert property (s_exec(OP_RET) |=> st.pc == $past(st.stk[sp_top]) ##0 s_ret_tail)
    else $error("RET not two cycles or wrong target");
  a_retax_load: assert property (s_exec(OP_RETAX) |=> st.wreg == $past(st.imm))
    else $error("RET with constant did not load");
  a_reti_gie: assert property (s_exec(OP_RETI) |=> global_irq_enable ##1 st.fsm == ST_IDLE)
    else $error("RETI did not set interrupt enable");
  a_rl_mem: assert property (s_exec(OP_RL) |=> st.mem[$past(idx)] == {$past(mop[6:0]), $past(mop[7])})
    else $error("RL wrong");
  a_rlc_carry: assert property (s_exec(OP_RLC) |=> st.cf == $past(mop[7])
    && st.mem[$past(idx)] == {$past(mop[6:0]), $past(st.cf)})
    else $error("RLC wrong");
  a_rrca_reg: assert property (s_exec(OP_RRCA) |=> st.cf == $past(mop[0])
    && st.wreg == {$past(st.cf), $past(mop[7:1])} && st.mem == $past(st.mem))
    else $error("RRCA wrong");
  a_halt_flags: assert property (s_exec(OP_HALT) |=> st.sleepf && !st.wdf && core_clk_stop)
    else $error("HALT flags wrong");

endmodule // mie_exec

// ---- test/testbench.sv ----
// Self-checking testbench for the execute unit, driven over its register bus.
`timescale 1ns/100ps
module testbench;
  import mie_pkg::*;
  // ----------------------------------------------------------------
  // Signals and design instance
  // ----------------------------------------------------------------
  logic        mclk = 1'b0;
  logic        sys_rst = 1'b1;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        core_clk_stop;
  logic        global_irq_enable;
  int          n_fail = 0;
  int          cmp_count = 0;

  // The clock toggles every half period of 20 ns.
  always #20 mclk = ~mclk;

  mie_exec i_mie_exec (
    .mclk(mclk), .sys_rst(sys_rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .core_clk_stop(core_clk_stop), .global_irq_enable(global_irq_enable)
  ); // mie_exec

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  // Prints the counts and the verdict, then ends the run.
  task automatic report_and_stop();
    $display("comparisons %0d, mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // Compares a seen value with the expected one and counts the result.
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // One bus transfer; the request is held until pready is seen high at an edge.
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    int n;
    @(posedge mclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge mclk);
    penable <= 1'b1;
    for (n = 0; n < 20; n++) begin
      @(posedge mclk);
      if (pready === 1'b1) break;
    end
    if (n == 20) begin
      n_fail++;
      report_and_stop();
    end
    r = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  // Write and read helpers that expect an accepted transfer.
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic        e;
    apb(1'b1, a, d, r, e);
    chk({31'h0, e}, 32'h0);
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] exp);
    logic [31:0] r;
    logic        e;
    apb(1'b0, a, 32'h0, r, e);
    chk(r, exp);
    chk({31'h0, e}, 32'h0);
  endtask

  // Byte address of data memory byte i.
  function automatic logic [11:0] ma(input logic [4:0] i);
    return OFS_MEM + {5'h00, i, 2'b00};
  endfunction

  // Loads the state, runs one instruction and checks register, flags, byte and counter.
  task automatic opchk(input logic [4:0] op, input logic [7:0] imm, input logic [11:0] opd,
                       input logic [7:0] w0, input logic [31:0] f0, input logic [7:0] m0,
                       input logic [7:0] ew, input logic [31:0] ef, input logic [7:0] em,
                       input logic [11:0] ep);
    wr(OFS_WREG, {24'h0, w0});
    wr(OFS_FLAGS, f0);
    wr(ma(opd[4:0]), {24'h0, m0});
    wr(OFS_PC, 32'h0000_0010);
    wr(OFS_INSTR, {4'h0, opd, imm, 3'h0, op});
    rd(OFS_WREG, {24'h0, ew});
    rd(OFS_FLAGS, ef);
    rd(ma(opd[4:0]), {24'h0, em});
    rd(OFS_PC, {20'h0, ep});
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  // Increment, moves, no-op and OR, with the zero flag driven both ways.
  task automatic t_data();
    opchk(OP_INC,   8'h00, 12'h003, 8'h00, 32'h8, 8'hFF, 8'h00, 32'h9, 8'h00, 12'h011);
    opchk(OP_INCA,  8'h00, 12'h004, 8'h00, 32'h9, 8'h41, 8'h42, 32'h8, 8'h41, 12'h011);
    opchk(OP_MOVAM, 8'h00, 12'h005, 8'h55, 32'h2, 8'h00, 8'h00, 32'h2, 8'h00, 12'h011);
    opchk(OP_MOVAX, 8'hA6, 12'h005, 8'h55, 32'h2, 8'h00, 8'hA6, 32'h2, 8'h00, 12'h011);
    opchk(OP_MOVMA, 8'h00, 12'h006, 8'h3C, 32'h2, 8'hC3, 8'h3C, 32'h2, 8'h3C, 12'h011);
    opchk(OP_NOP,   8'h00, 12'h007, 8'h5A, 32'hA, 8'h77, 8'h5A, 32'hA, 8'h77, 12'h011);
    opchk(OP_ORAM,  8'h00, 12'h007, 8'h00, 32'h8, 8'h00, 8'h00, 32'h9, 8'h00, 12'h011);
    opchk(OP_ORAX,  8'h30, 12'h007, 8'h03, 32'h9, 8'h00, 8'h33, 32'h8, 8'h00, 12'h011);
    opchk(OP_ORMM,  8'h00, 12'h008, 8'h0F, 32'h9, 8'hF0, 8'h0F, 32'h8, 8'hFF, 12'h011);
    // An unused opcode only steps the counter and leaves data and flags alone.
    opchk(5'h16,    8'h00, 12'h00B, 8'h66, 32'h3, 8'h99, 8'h66, 32'h3, 8'h99, 12'h011);
  endtask

  // Every rotate form, with carry chosen so that a plain rotate would differ.
  task automatic t_rot();
    opchk(OP_RL,   8'h00, 12'h009, 8'h11, 32'h8, 8'h96, 8'h11, 32'h8, 8'h2D, 12'h011);
    opchk(OP_RLA,  8'h00, 12'h009, 8'h11, 32'h8, 8'h96, 8'h2D, 32'h8, 8'h96, 12'h011);
    opchk(OP_RLC,  8'h00, 12'h009, 8'h11, 32'hA, 8'h16, 8'h11, 32'h8, 8'h2D, 12'h011);
    opchk(OP_RLCA, 8'h00, 12'h009, 8'h11, 32'h8, 8'h96, 8'h2C, 32'hA, 8'h96, 12'h011);
    opchk(OP_RR,   8'h00, 12'h00A, 8'h11, 32'h8, 8'h69, 8'h11, 32'h8, 8'hB4, 12'h011);
    opchk(OP_RRA,  8'h00, 12'h00A, 8'h11, 32'h8, 8'h69, 8'hB4, 32'h8, 8'h69, 12'h011);
    opchk(OP_RRC,  8'h00, 12'h00A, 8'h11, 32'hA, 8'h68, 8'h11, 32'h8, 8'hB4, 12'h011);
    opchk(OP_RRCA, 8'h00, 12'h00A, 8'h11, 32'h8, 8'h69, 8'h34, 32'hA, 8'h69, 12'h011);
  endtask

  // Jump and the three returns, each popping a value pushed just before.
  task automatic t_flow();
    opchk(OP_JMP,   8'h00, 12'h3A5, 8'h21, 32'hB, 8'h00, 8'h21, 32'hB, 8'h00, 12'h3A5);
    wr(OFS_STACK, 32'h0000_0123);
    rd(OFS_STACK, 32'h0000_0123);
    rd(OFS_SP, 32'h0000_0001);
    opchk(OP_RET,   8'h00, 12'h000, 8'h21, 32'hB, 8'h00, 8'h21, 32'hB, 8'h00, 12'h123);
    wr(OFS_STACK, 32'h0000_0045);
    opchk(OP_RETAX, 8'h7E, 12'h000, 8'h21, 32'h3, 8'h00, 8'h7E, 32'h3, 8'h00, 12'h045);
    wr(OFS_IRQCTL, 32'h0);
    // The output changes at the edge where the write lands, so look one edge later.
    @(posedge mclk);
    chk({31'h0, global_irq_enable}, 32'h0);
    wr(OFS_STACK, 32'h0000_02F0);
    opchk(OP_RETI,  8'h00, 12'h000, 8'h21, 32'h3, 8'h00, 8'h21, 32'h3, 8'h00, 12'h2F0);
    chk({31'h0, global_irq_enable}, 32'h1);
    rd(OFS_IRQCTL, 32'h1);
  endtask

  // Halt sets the sleep flag, clears the watchdog flag and refuses new work until woken.
  task automatic t_halt();
    logic [31:0] r;
    logic        e;
    opchk(OP_HALT, 8'h00, 12'h000, 8'h21, 32'h9, 8'h00, 8'h21, 32'h205, 8'h00, 12'h011);
    chk({31'h0, core_clk_stop}, 32'h1);
    apb(1'b1, OFS_INSTR, {27'h0, OP_NOP}, r, e);
    chk({31'h0, e}, 32'h1);
    rd(OFS_PC, 32'h011);
    wr(OFS_CTRL, 32'h1);
    // The wake takes effect at the edge that ends the write, so look one edge later.
    @(posedge mclk);
    chk({31'h0, core_clk_stop}, 32'h0);
    rd(OFS_FLAGS, 32'h005);
  endtask

  // Reset values and refused accesses to unmapped, misaligned and write-only places.
  task automatic t_bus();
    logic [31:0] r;
    logic        e;
    rd(OFS_WREG, 32'h0);
    rd(OFS_PC, 32'h0);
    rd(OFS_IRQCTL, 32'h0);
    chk({31'h0, global_irq_enable}, 32'h0);
    apb(1'b0, 12'h020, 32'h0, r, e);
    chk({31'h0, e}, 32'h1);
    apb(1'b0, OFS_INSTR, 32'h0, r, e);
    chk({31'h0, e}, 32'h1);
    apb(1'b1, 12'h102, 32'h0, r, e);
    chk({31'h0, e}, 32'h1);
    rd(OFS_CTRL, 32'h0);
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  // Holds reset for 20 cycles, then runs every scenario in turn.
  initial begin
    repeat (20) @(posedge mclk);
    sys_rst <= 1'b0;
    t_bus();
    t_data();
    t_rot();
    t_flow();
    t_halt();
    report_and_stop();
  end
endmodule // testbench
